// ---- hdl/isq_pkg.sv ----
// constants, types and field layout for instrument status and queues
// Operation
// RULE1 - five status registers share one bit layout
// RULE2 - bit 0 follows operate versus standby
// RULE3 - bit 7 set above 30 V programmed
// RULE4 - bit 10 trip flag, cleared operate/reset
// RULE5 - bit 11 set under remote control
// RULE6 - bit 12 output or thermocouple settled
// RULE7 - bit 13 booster amplifier active
// RULE8 - bit 14 ambient above verification temperature
// RULE9 - unassigned bits read zero, ignore writes
// RULE10 - query answers decimal text of 16 bits
// RULE11 - reading a change latch clears it
// RULE12 - host enables rising mask bit 12 too
// RULE13 - falling latch 1-to-0, rising latch 0-to-1
// RULE14 - latches cleared at power-on, clear-status
// RULE15 - summary bit set by masked latch bits
// RULE16 - both masks zero at power-up
// RULE17 - query answers load 800-character queue
// RULE18 - read removes characters; empty gives nothing
// RULE19 - message pending while queue not empty
// RULE20 - each error pushes its code
// RULE21 - error fetch pops oldest, zero if empty
// RULE22 - error pending while error queue occupied
// RULE23 - error queue emptied power-down, clear-status
// RULE24 - keep 15 errors, 16th overflow, discard
// RULE25 - describe query returns text for code
// RULE26 - same-cycle errors: command, execution, device
package isq_pkg;

    localparam int OQ_DEPTH = 800;
    localparam int EQ_DEPTH = 16;
    localparam int EQ_KEEP = 15;
    localparam logic [31:0] HV_LIMIT_MV = 32'h0000_7530;
    localparam logic [15:0] VALID_MASK = 16'h7c81;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [15:0] ERR_OVF_CODE = 16'h0001;
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [7:0] CHR_ZERO = 8'h30;
    localparam logic [7:0] CHR_LF = 8'h0a;
    localparam int MSG_MAX = 16;

    // one layout for state word, latches and masks
    typedef struct packed {
        logic unused_15;
        logic thermal_drift_flag;
        logic amplifier_attached_flag;
        logic output_stable_flag;
        logic host_controlled_flag;
        logic fault_fallback_flag;
        logic [1:0] unused_9_8;
        logic high_voltage_flag;
        logic [5:0] unused_6_1;
        logic output_active_flag;
    } isq_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] code;
    } isq_err_t;

    typedef struct packed {
        logic [MSG_MAX-1:0][7:0] chars;
        logic [4:0] len;
    } isq_msg_t;

    typedef enum logic [3:0] {
        ISQ_RD_STATE = 4'h0,
        ISQ_RD_FALL = 4'h1,
        ISQ_RD_RISE = 4'h2,
        ISQ_RD_FMASK = 4'h3,
        ISQ_RD_RMASK = 4'h4,
        ISQ_WR_FMASK = 4'h5,
        ISQ_WR_RMASK = 4'h6,
        ISQ_ERR_FETCH = 4'h7,
        ISQ_ERR_DESC = 4'h8,
        ISQ_CLR_STATUS = 4'h9,
        ISQ_RESET = 4'ha
    } isq_cmd_t;

    typedef enum logic [0:0] {
        ISQ_IDLE = 1'b0,
        ISQ_EMIT = 1'b1
    } isq_phase_t;

endpackage : isq_pkg

// ---- hdl/isq_err_queue.sv ----
// sixteen-entry error queue with overflow entry
module isq_err_queue (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic pop,
    input wire isq_pkg::isq_err_t err_cmd,
    input wire isq_pkg::isq_err_t err_exe,
    input wire isq_pkg::isq_err_t err_dev,
    output logic [15:0] head_code,
    output logic not_empty
);

    typedef struct packed {
        logic [isq_pkg::EQ_DEPTH-1:0][15:0] mem;
        logic [3:0] head;
        logic [4:0] count;
    } isq_eq_t;

    isq_eq_t q_r;
    isq_eq_t q_nxt;

    always_comb begin
        isq_pkg::isq_err_t src [3];
        logic [3:0] slot;
        q_nxt = q_r;
        slot = 4'h0;
        src[0] = err_cmd;
        src[1] = err_exe;
        src[2] = err_dev;
        if (clear) begin
            q_nxt.head = 4'h0; // [RULE23]
            q_nxt.count = 5'h00;
        end else if (pop && q_r.count != 5'h00) begin
            q_nxt.head = q_r.head + 4'h1; // [RULE21]
            q_nxt.count = q_r.count - 5'h01;
        end
        // fixed order; later sources see earlier inserts
        for (int i = 0; i < 3; i++) begin // [RULE26]
            if (src[i].valid) begin // [RULE20]
                slot = q_nxt.head + q_nxt.count[3:0];
                if (q_nxt.count < 5'(isq_pkg::EQ_KEEP)) begin
                    q_nxt.mem[slot] = src[i].code;
                    q_nxt.count = q_nxt.count + 5'h01;
                end else if (q_nxt.count == 5'(isq_pkg::EQ_KEEP)) begin
                    q_nxt.mem[slot] = isq_pkg::ERR_OVF_CODE; // [RULE24]
                    q_nxt.count = q_nxt.count + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign head_code = (q_r.count == 5'h00) ? isq_pkg::ERR_NONE
                       : q_r.mem[q_r.head]; // [RULE21]
    assign not_empty = (q_r.count != 5'h00);

endmodule : isq_err_queue

// ---- hdl/isq_status.sv ----
// instrument state word, change latches, masks and query queues
module isq_status #(
    parameter int OQ_DEPTH = isq_pkg::OQ_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire isq_pkg::isq_cmd_t cmd_code,
    input wire logic [15:0] cmd_arg,
    output logic cmd_ready,
    input wire logic out_read_req,
    output logic out_read_valid,
    output logic [7:0] out_read_data,
    input wire logic output_operate,
    input wire logic [31:0] prog_mv,
    input wire logic trip_event,
    input wire logic remote_mode,
    input wire logic output_settled,
    input wire logic tc_settled,
    input wire logic amp_active,
    input wire logic [15:0] ambient_temp,
    input wire logic [15:0] verify_temp,
    input wire isq_pkg::isq_err_t err_cmd,
    input wire isq_pkg::isq_err_t err_exe,
    input wire isq_pkg::isq_err_t err_dev,
    output logic change_summary_bit,
    output logic message_pending_bit,
    output logic error_pending_bit
);

    localparam int AW = $clog2(OQ_DEPTH);
    localparam logic [AW-1:0] PTR_LAST = AW'(OQ_DEPTH - 1);
    localparam logic [AW:0] CNT_FULL = (AW + 1)'(OQ_DEPTH);

    typedef struct packed {
        isq_pkg::isq_phase_t phase;
        isq_pkg::isq_msg_t msg;
        logic [4:0] idx;
        isq_pkg::isq_state_t state;
        logic [15:0] fall;
        logic [15:0] rise;
        logic [15:0] fmask;
        logic [15:0] rmask;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
        logic rd_valid;
        logic [7:0] rd_data;
        logic summary;
        logic mpend;
        logic epend;
        logic ready;
        logic operate_prev;
    } isq_ctl_t;

    isq_ctl_t ctl_r;
    isq_ctl_t ctl_nxt;
    logic [7:0] oq_mem [OQ_DEPTH];
    logic oq_push;
    logic [7:0] oq_char;
    logic eq_pop;
    logic eq_clear;
    logic [15:0] eq_head;
    logic eq_not_empty;

    // binary to five packed decimal digits
    function automatic logic [19:0] bin_to_bcd(input logic [15:0] v);
        logic [19:0] b;
        b = 20'h00000;
        for (int i = 15; i >= 0; i--) begin
            for (int d = 0; d < 5; d++) begin
                if (b[d*4 +: 4] >= 4'h5) begin
                    b[d*4 +: 4] = b[d*4 +: 4] + 4'h3;
                end
            end
            b = {b[18:0], v[i]};
        end
        return b;
    endfunction : bin_to_bcd

    // decimal text without leading zeros, line feed ended
    function automatic isq_pkg::isq_msg_t num_text(input logic [15:0] v);
        isq_pkg::isq_msg_t m;
        logic [19:0] b;
        logic seen;
        m = '0;
        b = bin_to_bcd(v);
        seen = 1'b0;
        for (int i = 4; i >= 0; i--) begin
            if (seen || b[i*4 +: 4] != 4'h0 || i == 0) begin
                m.chars[m.len[3:0]] = isq_pkg::CHR_ZERO + {4'h0, b[i*4 +: 4]};
                m.len = m.len + 5'h01;
                seen = 1'b1;
            end
        end
        m.chars[m.len[3:0]] = isq_pkg::CHR_LF;
        m.len = m.len + 5'h01;
        return m;
    endfunction : num_text

    // short description of an error code
    function automatic isq_pkg::isq_msg_t desc_text(input logic [15:0] c);
        isq_pkg::isq_msg_t m;
        logic [119:0] s;
        int n;
        m = '0;
        if (c == isq_pkg::ERR_NONE) begin
            s = 120'("NO ERROR");
            n = 8;
        end else if (c == isq_pkg::ERR_OVF_CODE) begin
            s = 120'("QUEUE OVERFLOW");
            n = 14;
        end else begin
            s = 120'("DEVICE ERROR");
            n = 12;
        end
        for (int k = 0; k < 14; k++) begin
            if (k < n) begin
                m.chars[k] = s[(n - 1 - k) * 8 +: 8];
            end
        end
        m.chars[n] = isq_pkg::CHR_LF;
        m.len = 5'(n + 1);
        return m;
    endfunction : desc_text

    always_comb begin
        isq_pkg::isq_state_t sw;
        logic [15:0] old_w;
        logic [15:0] new_w;
        logic pop;
        logic reset_cmd;
        logic clear_fall;
        logic clear_rise;
        logic clear_stat;
        ctl_nxt = ctl_r;
        sw = '0;
        old_w = ctl_r.state;
        new_w = 16'h0000;
        pop = 1'b0;
        reset_cmd = 1'b0;
        clear_fall = 1'b0;
        clear_rise = 1'b0;
        clear_stat = 1'b0;
        oq_push = 1'b0;
        oq_char = ctl_r.msg.chars[ctl_r.idx[3:0]];
        eq_pop = 1'b0;
        eq_clear = 1'b0;
        ctl_nxt.rd_valid = 1'b0;

        // command intake
        if (ctl_r.phase == isq_pkg::ISQ_IDLE && cmd_valid) begin
            case (cmd_code)
                isq_pkg::ISQ_RD_STATE: begin
                    ctl_nxt.msg = num_text(ctl_r.state); // [RULE10]
                end
                isq_pkg::ISQ_RD_FALL: begin
                    ctl_nxt.msg = num_text(ctl_r.fall);
                    clear_fall = 1'b1; // [RULE11]
                end
                isq_pkg::ISQ_RD_RISE: begin
                    ctl_nxt.msg = num_text(ctl_r.rise);
                    clear_rise = 1'b1; // [RULE11]
                end
                isq_pkg::ISQ_RD_FMASK: begin
                    ctl_nxt.msg = num_text(ctl_r.fmask);
                end
                isq_pkg::ISQ_RD_RMASK: begin
                    ctl_nxt.msg = num_text(ctl_r.rmask);
                end
                isq_pkg::ISQ_WR_FMASK: begin
                    ctl_nxt.fmask = cmd_arg & isq_pkg::VALID_MASK; // [RULE9]
                end
                isq_pkg::ISQ_WR_RMASK: begin
                    ctl_nxt.rmask = cmd_arg & isq_pkg::VALID_MASK; // [RULE9]
                end
                isq_pkg::ISQ_ERR_FETCH: begin
                    ctl_nxt.msg = num_text(eq_head); // [RULE21]
                    eq_pop = 1'b1;
                end
                isq_pkg::ISQ_ERR_DESC: begin
                    ctl_nxt.msg = desc_text(cmd_arg); // [RULE25]
                end
                isq_pkg::ISQ_CLR_STATUS: begin
                    clear_stat = 1'b1; // [RULE14]
                    eq_clear = 1'b1; // [RULE23]
                end
                isq_pkg::ISQ_RESET: begin
                    reset_cmd = 1'b1;
                end
                default: begin
                end
            endcase
            case (cmd_code)
                isq_pkg::ISQ_WR_FMASK, isq_pkg::ISQ_WR_RMASK,
                isq_pkg::ISQ_CLR_STATUS, isq_pkg::ISQ_RESET: begin
                    ctl_nxt.phase = isq_pkg::ISQ_IDLE;
                end
                default: begin
                    ctl_nxt.phase = isq_pkg::ISQ_EMIT; // [RULE17]
                    ctl_nxt.idx = 5'h00;
                    ctl_nxt.ready = 1'b0;
                end
            endcase
        end

        // host reads one character; empty queue gives no answer
        if (out_read_req && ctl_r.count != '0) begin
            pop = 1'b1; // [RULE18]
            ctl_nxt.rd_valid = 1'b1;
            ctl_nxt.rd_data = oq_mem[ctl_r.rd_ptr];
            ctl_nxt.rd_ptr = (ctl_r.rd_ptr == PTR_LAST) ? '0
                             : ctl_r.rd_ptr + AW'(1);
        end

        // answer text enters the queue, stalling while full
        if (ctl_r.phase == isq_pkg::ISQ_EMIT && ctl_r.count != CNT_FULL) begin
            oq_push = 1'b1; // [RULE17]
            ctl_nxt.wr_ptr = (ctl_r.wr_ptr == PTR_LAST) ? '0
                             : ctl_r.wr_ptr + AW'(1);
            ctl_nxt.idx = ctl_r.idx + 5'h01;
            if (ctl_r.idx == ctl_r.msg.len - 5'h01) begin
                ctl_nxt.phase = isq_pkg::ISQ_IDLE;
                ctl_nxt.ready = 1'b1;
            end
        end
        if (oq_push && !pop) begin
            ctl_nxt.count = ctl_r.count + (AW + 1)'(1);
        end else if (!oq_push && pop) begin
            ctl_nxt.count = ctl_r.count - (AW + 1)'(1);
        end

        // state word from live conditions
        sw.output_active_flag = output_operate; // [RULE2]
        sw.high_voltage_flag = (prog_mv > isq_pkg::HV_LIMIT_MV); // [RULE3]
        sw.host_controlled_flag = remote_mode; // [RULE5]
        sw.output_stable_flag = output_settled | tc_settled; // [RULE6]
        sw.amplifier_attached_flag = amp_active; // [RULE7]
        sw.thermal_drift_flag = (ambient_temp > verify_temp); // [RULE8]
        sw.fault_fallback_flag = ctl_r.state.fault_fallback_flag;
        if ((output_operate && !ctl_r.operate_prev) || reset_cmd) begin
            sw.fault_fallback_flag = 1'b0; // [RULE4]
        end
        if (trip_event) begin
            sw.fault_fallback_flag = 1'b1; // [RULE4]
        end
        new_w = sw & isq_pkg::VALID_MASK; // [RULE9]
        ctl_nxt.state = new_w; // [RULE1]
        ctl_nxt.operate_prev = output_operate;

        // change latches: new edges survive a same-cycle clear
        ctl_nxt.fall = ((clear_fall || clear_stat) ? 16'h0000 : ctl_r.fall)
                       | (old_w & ~new_w); // [RULE13]
        ctl_nxt.rise = ((clear_rise || clear_stat) ? 16'h0000 : ctl_r.rise)
                       | (~old_w & new_w); // [RULE13]

        ctl_nxt.summary = |((ctl_nxt.fall & ctl_r.fmask)
                            | (ctl_nxt.rise & ctl_r.rmask)); // [RULE15]
        ctl_nxt.mpend = (ctl_nxt.count != '0); // [RULE19]
        ctl_nxt.epend = eq_not_empty; // [RULE22]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_r <= '0;
            ctl_r.fmask <= isq_pkg::MASK_RST; // [RULE16]
            ctl_r.rmask <= isq_pkg::MASK_RST; // [RULE16]
            ctl_r.ready <= 1'b1;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (oq_push) begin
            oq_mem[ctl_r.wr_ptr] <= oq_char;
        end
    end

    isq_err_queue u_err_queue (
        .clk(clk),
        .rst_n(rst_n),
        .clear(eq_clear),
        .pop(eq_pop),
        .err_cmd(err_cmd),
        .err_exe(err_exe),
        .err_dev(err_dev),
        .head_code(eq_head),
        .not_empty(eq_not_empty)
    );

    assign cmd_ready = ctl_r.ready;
    assign out_read_valid = ctl_r.rd_valid;
    assign out_read_data = ctl_r.rd_data;
    assign change_summary_bit = ctl_r.summary;
    assign message_pending_bit = ctl_r.mpend;
    assign error_pending_bit = ctl_r.epend;

endmodule : isq_status

// ---- tb/isq_status_chk.sv ----
// concurrent checks on the status and queue ports
module isq_status_chk #(
    parameter int OQ_DEPTH = 800
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire isq_pkg::isq_cmd_t cmd_code,
    input wire logic [15:0] cmd_arg,
    input wire logic cmd_ready,
    input wire logic out_read_req,
    input wire logic out_read_valid,
    input wire logic [7:0] out_read_data,
    input wire logic output_operate,
    input wire logic [31:0] prog_mv,
    input wire logic trip_event,
    input wire logic remote_mode,
    input wire logic output_settled,
    input wire logic tc_settled,
    input wire logic amp_active,
    input wire logic [15:0] ambient_temp,
    input wire logic [15:0] verify_temp,
    input wire isq_pkg::isq_err_t err_cmd,
    input wire isq_pkg::isq_err_t err_exe,
    input wire isq_pkg::isq_err_t err_dev,
    input wire logic change_summary_bit,
    input wire logic message_pending_bit,
    input wire logic error_pending_bit
);
    timeunit 1ns;
    timeprecision 100ps;
    logic clr_now;
    logic any_err;
    assign clr_now = cmd_valid && cmd_ready
        && cmd_code == isq_pkg::ISQ_CLR_STATUS;
    assign any_err = err_cmd.valid || err_exe.valid || err_dev.valid;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence query_taken;
        cmd_valid && cmd_ready && cmd_code <= isq_pkg::ISQ_ERR_DESC
        && !(cmd_code inside {isq_pkg::ISQ_WR_FMASK, isq_pkg::ISQ_WR_RMASK});
    endsequence
    sequence quiet;
        !any_err;
    endsequence
    ready_drop_a: assert property (query_taken |=> !cmd_ready)
        else $error("ready stayed high after a query");
    ready_back_a: assert property (query_taken
        |-> ##[2:40] cmd_ready)
        else $error("query answer never completed");
    msg_rise_a: assert property (query_taken
        |-> ##[1:3] message_pending_bit)
        else $error("message pending missing after a query");
    read_origin_a: assert property (out_read_valid
        |-> $past(out_read_req))
        else $error("character given without a read");
    data_hold_a: assert property ($past(rst_n)
        && !$past(out_read_req) |-> $stable(out_read_data))
        else $error("read data moved unread");
    err_pend_a: assert property (any_err && !clr_now ##1 !clr_now
        |=> error_pending_bit) else $error("error pending not raised");
    err_clear_a: assert property (clr_now ##0 quiet ##1 quiet
        |=> !error_pending_bit) else $error("error queue kept after clear");
    reset_state_a: assert property ($rose(rst_n) |-> cmd_ready
        && !change_summary_bit && !message_pending_bit
        && !error_pending_bit && !out_read_valid)
        else $error("outputs not idle after reset");
endmodule : isq_status_chk

bind isq_status isq_status_chk #(.OQ_DEPTH(OQ_DEPTH)) chk_u (.clk, .rst_n,
    .cmd_valid, .cmd_code, .cmd_arg, .cmd_ready, .out_read_req,
    .out_read_valid, .out_read_data, .output_operate, .prog_mv, .trip_event,
    .remote_mode, .output_settled, .tc_settled, .amp_active, .ambient_temp,
    .verify_temp, .err_cmd, .err_exe, .err_dev, .change_summary_bit,
    .message_pending_bit, .error_pending_bit);

// ---- tb/isq_host.sv ----
// host controller model: commands, queries and output queue reads
module isq_host (
    input wire logic clk,
    output logic cmd_valid,
    output isq_pkg::isq_cmd_t cmd_code,
    output logic [15:0] cmd_arg,
    input wire logic cmd_ready,
    output logic out_read_req,
    input wire logic out_read_valid,
    input wire logic [7:0] out_read_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic timed_out = 1'b0;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = isq_pkg::ISQ_RD_STATE;
        cmd_arg = 16'h0000;
        out_read_req = 1'b0;
    end
    task automatic wait_ready();
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 2000) begin
            @(posedge clk) #1 n++;
        end
        if (n == 2000) timed_out = 1'b1;
    endtask : wait_ready
    task automatic send(input isq_pkg::isq_cmd_t c, input logic [15:0] a);
        wait_ready();
        cmd_code = c;
        cmd_arg = a;
        cmd_valid = 1'b1;
        @(posedge clk) #1 cmd_valid = 1'b0;
        // released qualifier shows a changed value
        cmd_arg = ~a;
        // one idle edge keeps back-to-back strobes apart
        @(posedge clk) #1;
    endtask : send
    // val is the decimal answer, all ones when no full line came back
    task automatic query(input isq_pkg::isq_cmd_t c, input logic [15:0] a,
            input int gap, output logic [31:0] val, output logic [7:0] first);
        val = 32'h0000_0000;
        first = 8'h00;
        send(c, a);
        wait_ready();
        for (int k = 0; k < 20; k++) begin
            repeat (gap + 1) @(posedge clk);
            #1 out_read_req = 1'b1;
            @(posedge clk) #1 out_read_req = 1'b0;
            if (out_read_valid !== 1'b1) begin
                val = 32'hffff_ffff;
                break;
            end
            if (out_read_data === isq_pkg::CHR_LF) break;
            if (k == 0) first = out_read_data;
            val = val * 32'h0000_000a + (out_read_data - isq_pkg::CHR_ZERO);
        end
    endtask : query
    task automatic probe(output logic got);
        @(posedge clk) #1 out_read_req = 1'b1;
        @(posedge clk) #1 out_read_req = 1'b0;
        got = out_read_valid;
    endtask : probe
endmodule : isq_host

// ---- tb/testbench.sv ----
// self-checking bench for the status registers and queues
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid, cmd_ready, out_read_req, out_read_valid, got;
    isq_pkg::isq_cmd_t cmd_code;
    logic [15:0] cmd_arg;
    logic [7:0] out_read_data, f;
    logic output_operate = 1'b0, trip_event = 1'b0, remote_mode = 1'b0;
    logic output_settled = 1'b0, tc_settled = 1'b0, amp_active = 1'b0;
    logic [31:0] prog_mv = 32'h0000_0000;
    logic [31:0] v;
    logic [15:0] ambient_temp = 16'h0000, verify_temp = 16'h0000;
    isq_pkg::isq_err_t err_cmd = '0, err_exe = '0, err_dev = '0;
    logic change_summary_bit, message_pending_bit, error_pending_bit;
    int n_errors = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    isq_status #(.OQ_DEPTH(800)) dut_u (.clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
        .cmd_ready(cmd_ready), .out_read_req(out_read_req),
        .out_read_valid(out_read_valid), .out_read_data(out_read_data),
        .output_operate(output_operate), .prog_mv(prog_mv),
        .trip_event(trip_event), .remote_mode(remote_mode),
        .output_settled(output_settled), .tc_settled(tc_settled),
        .amp_active(amp_active), .ambient_temp(ambient_temp),
        .verify_temp(verify_temp), .err_cmd(err_cmd), .err_exe(err_exe),
        .err_dev(err_dev), .change_summary_bit(change_summary_bit),
        .message_pending_bit(message_pending_bit),
        .error_pending_bit(error_pending_bit));
    isq_host host_u (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .out_read_req(out_read_req),
        .out_read_valid(out_read_valid), .out_read_data(out_read_data));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic rd(input isq_pkg::isq_cmd_t c, input logic [31:0] exp);
        host_u.query(c, 16'h0000, 0, v, f);
        check(v, exp);
    endtask : rd
    task automatic desc(input logic [15:0] code, input logic [7:0] ch);
        host_u.query(isq_pkg::ISQ_ERR_DESC, code, 2, v, f);
        check(f, ch);
    endtask : desc
    task automatic t_reset_vals();
        rd(isq_pkg::ISQ_RD_FMASK, 32'h0);
        rd(isq_pkg::ISQ_RD_RMASK, 32'h0);
        rd(isq_pkg::ISQ_RD_FALL, 32'h0);
        rd(isq_pkg::ISQ_RD_RISE, 32'h0);
    endtask : t_reset_vals
    task automatic t_state();
        output_operate = 1'b1;
        prog_mv = 32'h0000_7531;
        remote_mode = 1'b1;
        output_settled = 1'b1;
        amp_active = 1'b1;
        ambient_temp = 16'h0101;
        verify_temp = 16'h0100;
        tick(4);
        rd(isq_pkg::ISQ_RD_STATE, 32'h7881);
        rd(isq_pkg::ISQ_RD_RISE, 32'h7881);
        output_operate = 1'b0;
        prog_mv = 32'h0000_7530;
        remote_mode = 1'b0;
        output_settled = 1'b0;
        tc_settled = 1'b1;
        amp_active = 1'b0;
        ambient_temp = 16'h0100;
        tick(4);
        rd(isq_pkg::ISQ_RD_STATE, 32'h1000);
        rd(isq_pkg::ISQ_RD_FALL, 32'h6881);
    endtask : t_state
    task automatic t_fault();
        tc_settled = 1'b0;
        trip_event = 1'b1;
        tick(1);
        trip_event = 1'b0;
        tick(3);
        rd(isq_pkg::ISQ_RD_STATE, 32'h0400);
        host_u.send(isq_pkg::ISQ_RESET, 16'h0000);
        tick(3);
        rd(isq_pkg::ISQ_RD_STATE, 32'h0);
        trip_event = 1'b1;
        tick(1);
        trip_event = 1'b0;
        output_operate = 1'b1;
        tick(4);
        rd(isq_pkg::ISQ_RD_STATE, 32'h1);
        output_operate = 1'b0;
        tick(3);
    endtask : t_fault
    task automatic t_latch();
        host_u.send(isq_pkg::ISQ_CLR_STATUS, 16'h0000);
        host_u.send(isq_pkg::ISQ_WR_FMASK, 16'hffff);
        rd(isq_pkg::ISQ_RD_FMASK, 32'h7c81);
        host_u.send(isq_pkg::ISQ_WR_RMASK, 16'h1000);
        host_u.send(isq_pkg::ISQ_WR_FMASK, 16'h0000);
        rd(isq_pkg::ISQ_RD_RMASK, 32'h1000);
        output_settled = 1'b1;
        tick(3);
        check(change_summary_bit, 32'h1);
        rd(isq_pkg::ISQ_RD_RISE, 32'h1000);
        check(change_summary_bit, 32'h0);
        rd(isq_pkg::ISQ_RD_RISE, 32'h0);
        output_settled = 1'b0;
        tick(3);
        check(change_summary_bit, 32'h0);
        rd(isq_pkg::ISQ_RD_FALL, 32'h1000);
        output_settled = 1'b1;
        tick(3);
        host_u.send(isq_pkg::ISQ_CLR_STATUS, 16'h0000);
        rd(isq_pkg::ISQ_RD_RISE, 32'h0);
    endtask : t_latch
    task automatic t_errors();
        err_cmd = '{1'b1, 16'h0064};
        err_exe = '{1'b1, 16'h00c8};
        err_dev = '{1'b1, 16'h012c};
        tick(1);
        {err_cmd, err_exe, err_dev} = '0;
        tick(2);
        check(error_pending_bit, 32'h1);
        rd(isq_pkg::ISQ_ERR_FETCH, 32'h64);
        rd(isq_pkg::ISQ_ERR_FETCH, 32'hc8);
        rd(isq_pkg::ISQ_ERR_FETCH, 32'h12c);
        check(error_pending_bit, 32'h0);
        rd(isq_pkg::ISQ_ERR_FETCH, 32'h0);
        for (int i = 0; i < 20; i++) begin
            err_cmd = '{1'b1, 16'h0100 + i[15:0]};
            tick(1);
        end
        err_cmd = '0;
        for (int i = 0; i < 15; i++) begin
            rd(isq_pkg::ISQ_ERR_FETCH, 32'h100 + i);
        end
        rd(isq_pkg::ISQ_ERR_FETCH, 32'h1);
        rd(isq_pkg::ISQ_ERR_FETCH, 32'h0);
        err_exe = '{1'b1, 16'h0007};
        tick(1);
        err_exe = '0;
        tick(2);
        host_u.send(isq_pkg::ISQ_CLR_STATUS, 16'h0000);
        tick(2);
        check(error_pending_bit, 32'h0);
        rd(isq_pkg::ISQ_ERR_FETCH, 32'h0);
        desc(16'h0000, 8'h4e);
        desc(16'h0001, 8'h51);
        desc(16'h0005, 8'h44);
    endtask : t_errors
    task automatic t_empty();
        host_u.probe(got);
        check(got, 32'h0);
        check(message_pending_bit, 32'h0);
    endtask : t_empty
    task automatic complete_run();
        if (host_u.timed_out) n_errors++;
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    initial begin
        tick(6);
        rst_n = 1'b1;
        tick(2);
        t_reset_vals();
        t_state();
        t_fault();
        t_latch();
        t_errors();
        t_empty();
        complete_run();
    end
    // about thirty times the expected run length
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end
endmodule : testbench
